//--- core/hspp_top.sv
// Purpose: host access port, framed serial slave or 8-bit indirect bus
// Assumes: memory answers each read within 4 ref_clk cycles of req_ready
// Notes: sclk is oversampled by ref_clk; all pins pass two flip-flops
`timescale 1ns/1ps
`include "hspp_cfg.svh"
module hspp_top #(
    parameter int DEPTH = `HSPP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host interface select strap
    input wire logic [3:0] host_if_select,
    // serial pins
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // parallel pins
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic [1:0] bus_addr,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    // internal access requests
    output logic req_valid,
    output hspp_pkg::hspp_req_s req,
    input wire logic req_ready,
    // internal read answers
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    // status
    output logic spi_active,
    output logic par_active,
    output logic host_busy
);
    hspp_pkg::hspp_top_s q, d;
    logic fifo_in_ready;
    logic spi_on, par_on, par_sel;
    logic sclk_rise, sclk_fall;
    logic rd_start, rd_end, wr_end;
    logic [7:0] rx_byte;
    logic [15:0] rx_word, off;

    // build one internal access
    function automatic hspp_pkg::hspp_req_s mk_req(input logic we, input logic [15:0] a,
                                                   input logic [7:0] v);
        hspp_pkg::hspp_req_s r;
        r.we = we;
        r.addr = a;
        r.data = v;
        return r;
    endfunction

    // port selection and edge detection from synchronised copies
    assign spi_on = q.sel_s2 == `HSPP_SEL_SPI;
    assign par_on = (q.sel_s2 & `HSPP_SEL_PAR_MASK) == `HSPP_SEL_PAR;
    assign par_sel = par_on & ~q.pcs_s2;
    assign sclk_rise = q.sclk_s2 & ~q.sclk_s3;
    assign sclk_fall = ~q.sclk_s2 & q.sclk_s3;
    assign rd_start = q.prd_s3 & ~q.prd_s2;
    assign rd_end = ~q.prd_s3 & q.prd_s2;
    assign wr_end = ~q.pwr_s3 & q.pwr_s2;
    assign rx_byte = {q.sh[6:0], q.mosi_s2};
    assign rx_word = {q.sh[14:0], q.mosi_s2};
    assign off = {q.off_hi, q.off_lo};

    // next state of the whole port
    always_comb begin
        d = q;
        // two-stage synchronisers, third stage only for edges
        d.sclk_s1 = sclk;
        d.sclk_s2 = q.sclk_s1;
        d.sclk_s3 = q.sclk_s2;
        d.scs_s1 = scs_n;
        d.scs_s2 = q.scs_s1;
        d.mosi_s1 = mosi;
        d.mosi_s2 = q.mosi_s1;
        d.sel_s1 = host_if_select;
        d.sel_s2 = q.sel_s1;
        d.pcs_s1 = bus_cs_n;
        d.pcs_s2 = q.pcs_s1;
        d.prd_s1 = bus_rd_n;
        d.prd_s2 = q.prd_s1;
        d.prd_s3 = q.prd_s2;
        d.pwr_s1 = bus_wr_n;
        d.pwr_s2 = q.pwr_s1;
        d.pwr_s3 = q.pwr_s2;
        d.pad_s1 = bus_addr;
        d.pad_s2 = q.pad_s1;
        d.pdi_s1 = bus_data_in;
        d.pdi_s2 = q.pdi_s1;
        // pending request leaves once the buffer takes it
        if (q.push_vld && fifo_in_ready) d.push_vld = 1'b0;
        // read answers land in the serial buffer, and in the bus latch only in parallel mode
        if (rsp_valid) begin
            d.rbuf = rsp_data;
            if (par_on) d.pdo = rsp_data;
        end
        // serial frame engine; a released select restarts the frame
        if (!spi_on || q.scs_s2) begin
            d.state = hspp_pkg::HSPP_CTRL;
            d.bcnt = '0;
            d.load_pend = 1'b0;
            d.miso = 1'b0;
            d.tx = '0;
        end else if (sclk_rise) begin
            d.sh = rx_word;
            d.bcnt = 4'(q.bcnt + 4'h1);
            unique case (q.state)
                hspp_pkg::HSPP_CTRL: begin
                    if (q.bcnt == `HSPP_CTRL_LAST) begin
                        d.bcnt = '0;
                        d.is_read = rx_byte == `HSPP_CMD_RD;
                        if (rx_byte == `HSPP_CMD_WR || rx_byte == `HSPP_CMD_RD) d.state = hspp_pkg::HSPP_ADDR;
                        else d.state = hspp_pkg::HSPP_SKIP;
                    end
                end
                hspp_pkg::HSPP_ADDR: begin
                    if (q.bcnt == `HSPP_ADDR_LAST) begin
                        d.bcnt = '0;
                        d.spi_addr = rx_word;
                        d.state = hspp_pkg::HSPP_DATA;
                        if (q.is_read) begin
                            d.push_vld = 1'b1;
                            d.push = mk_req(1'b0, rx_word, 8'h00);
                            d.load_pend = 1'b1;
                        end
                    end
                end
                hspp_pkg::HSPP_DATA: begin
                    if (q.bcnt == `HSPP_DATA_LAST) begin
                        d.bcnt = '0;
                        if (q.is_read) d.load_pend = 1'b1;
                        else begin
                            d.push_vld = 1'b1;
                            d.push = mk_req(1'b1, q.spi_addr, rx_byte);
                            d.spi_addr = 16'(q.spi_addr + 16'h0001);
                        end
                    end
                end
                hspp_pkg::HSPP_SKIP: begin
                    d.bcnt = '0;
                end
            endcase
        end else if (sclk_fall) begin
            // falling edge presents the next bit, msb first
            if (q.load_pend) begin
                d.miso = q.rbuf[7];
                d.tx = {q.rbuf[6:0], 1'b0};
                d.load_pend = 1'b0;
                d.spi_addr = 16'(q.spi_addr + 16'h0001);
                d.push_vld = 1'b1;
                d.push = mk_req(1'b0, 16'(q.spi_addr + 16'h0001), 8'h00);
            end else begin
                d.miso = q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
            end
        end
        // parallel read: register locations answer at once
        if (par_sel && rd_start) begin
            unique case (q.pad_s2)
                `HSPP_LOC_MODE: d.pdo = q.mode;
                `HSPP_LOC_OFF_HI: d.pdo = q.off_hi;
                `HSPP_LOC_OFF_LO: d.pdo = q.off_lo;
                `HSPP_LOC_DATA: begin
                    d.push_vld = 1'b1;
                    d.push = mk_req(1'b0, off, 8'h00);
                end
            endcase
        end
        // data location read ends: step the offset
        if (par_sel && rd_end && q.pad_s2 == `HSPP_LOC_DATA) begin
            {d.off_hi, d.off_lo} = 16'(off + 16'h0001);
        end
        // parallel write takes data at the strobe release
        if (par_sel && wr_end) begin
            unique case (q.pad_s2)
                `HSPP_LOC_MODE: d.mode = q.pdi_s2;
                `HSPP_LOC_OFF_HI: d.off_hi = q.pdi_s2;
                `HSPP_LOC_OFF_LO: d.off_lo = q.pdi_s2;
                `HSPP_LOC_DATA: begin
                    d.push_vld = 1'b1;
                    d.push = mk_req(1'b1, off, q.pdi_s2);
                    {d.off_hi, d.off_lo} = 16'(off + 16'h0001);
                end
            endcase
        end
    end

    // state register, clocked by the core clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.scs_s1 <= 1'b1;
            q.scs_s2 <= 1'b1;
            q.pcs_s1 <= 1'b1;
            q.pcs_s2 <= 1'b1;
            q.prd_s1 <= 1'b1;
            q.prd_s2 <= 1'b1;
            q.prd_s3 <= 1'b1;
            q.pwr_s1 <= 1'b1;
            q.pwr_s2 <= 1'b1;
            q.pwr_s3 <= 1'b1;
            q.mode <= `HSPP_MODE_RST;
            q.off_hi <= `HSPP_OFF_RST;
            q.off_lo <= `HSPP_OFF_RST;
        end else begin
            q <= d;
        end
    end

    // request buffer between the host ports and the internal space
    hspp_fifo #(
        .WIDTH($bits(hspp_pkg::hspp_req_s)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(q.push_vld),
        .in_data(q.push),
        .in_ready(fifo_in_ready),
        .out_valid(req_valid),
        .out_data(req),
        .out_ready(req_ready)
    );

    // pin and status outputs
    assign miso = q.miso;
    assign miso_oe = spi_on & ~q.scs_s2;
    assign bus_data_out = q.pdo;
    assign bus_data_oe = par_sel & ~q.prd_s2;
    assign spi_active = spi_on;
    assign par_active = par_on;
    assign host_busy = ~fifo_in_ready;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_wr_byte;
        q.state == hspp_pkg::HSPP_DATA && !q.is_read && sclk_rise && q.bcnt == `HSPP_DATA_LAST
            && !q.scs_s2 && spi_on;
    endsequence
    sequence s_ctrl_end;
        q.state == hspp_pkg::HSPP_CTRL && sclk_rise && q.bcnt == `HSPP_CTRL_LAST && !q.scs_s2 && spi_on;
    endsequence
    sequence s_par_data_wr;
        par_sel && wr_end && q.pad_s2 == `HSPP_LOC_DATA;
    endsequence
    sequence s_addr_end;
        q.state == hspp_pkg::HSPP_ADDR && sclk_rise && q.bcnt == `HSPP_ADDR_LAST && !q.scs_s2 && spi_on;
    endsequence
    sequence s_load_fall;
        q.load_pend && sclk_fall && !q.scs_s2 && spi_on;
    endsequence
    sequence s_par_data_rd;
        par_sel && rd_end && q.pad_s2 == `HSPP_LOC_DATA;
    endsequence

    chk_serial_oe_mode: assert property (miso_oe |-> $past(host_if_select, 2) == `HSPP_SEL_SPI)
        else $error("miso driven outside serial mode");
    chk_par_oe_mode: assert property (bus_data_oe
        |-> ($past(host_if_select, 2) & `HSPP_SEL_PAR_MASK) == `HSPP_SEL_PAR)
        else $error("bus data driven outside parallel mode");
    chk_frame_restart: assert property (q.scs_s2 |=> q.state == hspp_pkg::HSPP_CTRL && q.bcnt == 4'h0)
        else $error("frame not restarted on release");
    chk_bad_ctrl: assert property (s_ctrl_end ##0 (rx_byte != 8'hF0 && rx_byte != 8'h0F)
        |=> q.state == hspp_pkg::HSPP_SKIP)
        else $error("unknown control byte accepted");
    chk_ctrl_read: assert property (s_ctrl_end ##0 rx_byte == 8'h0F
        |=> q.state == hspp_pkg::HSPP_ADDR && q.is_read)
        else $error("read control byte not taken");
    chk_serial_write: assert property (s_wr_byte |=> q.push_vld && q.push.we
        && q.push.addr == $past(q.spi_addr) && q.push.data == $past(rx_byte))
        else $error("serial write byte not queued");
    chk_serial_inc: assert property (s_wr_byte |=> q.spi_addr == 16'($past(q.spi_addr) + 16'h0001))
        else $error("serial offset not advanced");
    chk_miso_fall: assert property (sclk_fall && !q.load_pend && !q.scs_s2 && spi_on
        |=> q.miso == $past(q.tx[7]) ##1 $stable(q.miso))
        else $error("miso not from shift msb on fall");
    chk_miso_hold: assert property (!sclk_fall && !q.scs_s2 && spi_on && !$past(q.scs_s2)
        |=> q.miso == $past(q.miso))
        else $error("miso changed without falling sclk");
    chk_par_inc: assert property (s_par_data_wr
        |=> {q.off_hi, q.off_lo} == 16'($past(off) + 16'h0001) ##0 q.push_vld && q.push.we)
        else $error("parallel data write did not step offset");
    chk_par_mode_wr: assert property (par_sel && wr_end && q.pad_s2 == 2'h0
        |=> q.mode == $past(q.pdi_s2))
        else $error("mode register write lost");
    chk_data_stay: assert property (s_wr_byte |=> q.state == hspp_pkg::HSPP_DATA)
        else $error("data phase ended before release");

    // serial control, address phase, read issue and prefetch
    chk_ctrl_write: assert property (s_ctrl_end ##0 rx_byte == 8'hF0
        |=> q.state == hspp_pkg::HSPP_ADDR && !q.is_read)
        else $error("write control byte not taken");
    chk_skip_hold: assert property (q.state == hspp_pkg::HSPP_SKIP && !q.scs_s2 && spi_on
        |=> q.state == hspp_pkg::HSPP_SKIP)
        else $error("ignored frame left the skip state");
    chk_addr_take: assert property (s_addr_end
        |=> q.spi_addr == $past(rx_word) && q.state == hspp_pkg::HSPP_DATA)
        else $error("serial start address not taken");
    chk_read_first: assert property (s_addr_end ##0 q.is_read
        |=> q.push_vld && !q.push.we && q.push.addr == $past(rx_word) && q.load_pend)
        else $error("serial read not issued at address end");
    chk_read_load: assert property (s_load_fall
        |=> q.miso == $past(q.rbuf[7]) && !q.load_pend)
        else $error("read byte not loaded msb first");
    chk_read_next: assert property (s_load_fall
        |=> q.push_vld && !q.push.we && q.push.addr == 16'($past(q.spi_addr) + 16'h0001))
        else $error("next serial read not issued");

    // parallel register locations and data reads
    chk_par_rd_issue: assert property (par_sel && rd_start && q.pad_s2 == `HSPP_LOC_DATA
        |=> q.push_vld && !q.push.we && q.push.addr == $past(off))
        else $error("parallel data read not issued");
    chk_par_rd_inc: assert property (s_par_data_rd
        |=> {q.off_hi, q.off_lo} == 16'($past(off) + 16'h0001))
        else $error("parallel data read did not step offset");
    chk_par_reg_rd: assert property (par_sel && rd_start && q.pad_s2 == `HSPP_LOC_MODE
        |=> q.pdo == $past(q.mode))
        else $error("mode register read wrong");
    chk_par_hi_wr: assert property (par_sel && wr_end && q.pad_s2 == `HSPP_LOC_OFF_HI
        |=> q.off_hi == $past(q.pdi_s2))
        else $error("offset high write lost");
    chk_par_lo_wr: assert property (par_sel && wr_end && q.pad_s2 == `HSPP_LOC_OFF_LO
        |=> q.off_lo == $past(q.pdi_s2))
        else $error("offset low write lost");
endmodule // hspp_top

//--- core/hspp_cfg.svh
// Purpose: constants of the host serial/parallel access port
// Assumes: included by bare name
// Notes: serial phase counts are in sclk bits, the buffer depth in entries
`ifndef HSPP_CFG_SVH
`define HSPP_CFG_SVH
// host interface select codes
`define HSPP_SEL_SPI 4'h0
`define HSPP_SEL_PAR 4'h4
`define HSPP_SEL_PAR_MASK 4'hE
// serial control byte values
`define HSPP_CMD_WR 8'hF0
`define HSPP_CMD_RD 8'h0F
// parallel indirect locations
`define HSPP_LOC_MODE 2'h0
`define HSPP_LOC_OFF_HI 2'h1
`define HSPP_LOC_OFF_LO 2'h2
`define HSPP_LOC_DATA 2'h3
// reset values
`define HSPP_MODE_RST 8'h00
`define HSPP_OFF_RST 8'h00
// index of the last bit of each serial phase
`define HSPP_CTRL_LAST 4'h7
`define HSPP_ADDR_LAST 4'hF
`define HSPP_DATA_LAST 4'h7
// request buffer depth
`define HSPP_FIFO_DEPTH 16
`endif

//--- core/hspp_pkg.sv
// Purpose: types of the host serial/parallel access port
// Assumes: nothing
// Notes: state of the top module is one packed struct
package hspp_pkg;
    typedef enum logic [1:0] {HSPP_CTRL, HSPP_ADDR, HSPP_DATA, HSPP_SKIP} hspp_state_e;
    // one access toward the internal register and buffer space
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } hspp_req_s;
    typedef struct packed {
        logic sclk_s1, sclk_s2, sclk_s3;
        logic scs_s1, scs_s2;
        logic mosi_s1, mosi_s2;
        logic [3:0] sel_s1, sel_s2;
        logic pcs_s1, pcs_s2;
        logic prd_s1, prd_s2, prd_s3;
        logic pwr_s1, pwr_s2, pwr_s3;
        logic [1:0] pad_s1, pad_s2;
        logic [7:0] pdi_s1, pdi_s2;
        hspp_state_e state;
        logic [3:0] bcnt;
        logic [15:0] sh;
        logic is_read;
        logic [7:0] tx;
        logic miso;
        logic load_pend;
        logic [15:0] spi_addr;
        logic [7:0] mode, off_hi, off_lo, pdo, rbuf;
        logic push_vld;
        hspp_req_s push;
    } hspp_top_s;
endpackage

//--- core/hspp_fifo.sv
// Purpose: request buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from a count
`timescale 1ns/1ps
module hspp_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp, rp;
        logic [AW:0] cnt;
    } hspp_fifo_s;
    hspp_fifo_s q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;
    assign in_ready = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = mem[q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // pointer and count update
    always_comb begin
        d = q;
        if (push) d.wp = q.wp + 1'b1;
        if (pop) d.rp = q.rp + 1'b1;
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) q <= '0;
        else q <= d;
    end
    // storage write
    always_ff @(posedge ref_clk) begin
        if (push) mem[q.wp] <= in_data;
    end
endmodule // hspp_fifo

//--- testbench/hspp_host_model.sv
// Purpose: host model, serial master in mode 0 or 3 and 8-bit indirect bus master
// Assumes: driven at the falling edge of ref_clk; sclk half period is 8 ref_clk cycles (64 ns period)
// Notes: released data lines toggle every cycle so a stale value never passes for a good one
`timescale 1ns/1ps
module hspp_host_model (
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic sclk,
    output logic scs_n,
    output logic mosi,
    input wire logic miso,
    // parallel pins
    output logic bus_cs_n,
    output logic bus_rd_n,
    output logic bus_wr_n,
    output logic [1:0] bus_addr,
    output logic [7:0] bus_data_in,
    input wire logic [7:0] bus_data_out
);
    // idle levels at time zero
    initial begin
        sclk = 1'b0;
        scs_n = 1'b1;
        mosi = 1'b0;
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_addr = 2'h0;
        bus_data_in = 8'h00;
    end
    // released data lines change every cycle
    always @(negedge ref_clk) begin
        if (scs_n) begin
            mosi <= ~mosi;
        end
        if (bus_cs_n) begin
            bus_data_in <= ~bus_data_in;
        end
    end
    // one frame: select, n bytes msb first, release
    task automatic spi_frame(input logic cpol, input logic [7:0] tx [8], input int n, output logic [7:0] rx [8]);
        // clock reaches its idle level while still deselected, so no stray edge falls in the frame
        @(negedge ref_clk);
        sclk <= cpol;
        repeat (4) @(negedge ref_clk);
        scs_n <= 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                sclk <= 1'b0;
                mosi <= tx[b][i];
                repeat (8) @(negedge ref_clk);
                sclk <= 1'b1;
                rx[b][i] = miso;
                repeat (8) @(negedge ref_clk);
            end
        end
        sclk <= cpol;
        repeat (4) @(negedge ref_clk);
        scs_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
    // bus write: strobe low for six core clocks
    task automatic par_write(input logic [1:0] loc, input logic [7:0] d);
        @(negedge ref_clk);
        bus_addr <= loc;
        bus_cs_n <= 1'b0;
        @(negedge ref_clk);
        bus_data_in <= d;
        bus_wr_n <= 1'b0;
        repeat (6) @(negedge ref_clk);
        bus_wr_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        bus_cs_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
    // bus read: data taken just before the strobe rises
    task automatic par_read(input logic [1:0] loc, output logic [7:0] d);
        @(negedge ref_clk);
        bus_addr <= loc;
        bus_cs_n <= 1'b0;
        @(negedge ref_clk);
        bus_rd_n <= 1'b0;
        repeat (16) @(negedge ref_clk);
        d = bus_data_out;
        bus_rd_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        bus_cs_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule // hspp_host_model

//--- testbench/hspp_top_tb.sv
// Purpose: self-checking bench of the host access port with a behavioural model
// Assumes: memory sink answers reads on the cycle after taking them
// Notes: random stalls on the sink only during bus tests, serial reads need a prompt answer
`timescale 1ns/1ps
`include "hspp_cfg.svh"
module hspp_top_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] host_if_select = 4'h0;
    logic sclk, scs_n, mosi, miso, miso_oe;
    logic bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe;
    logic [1:0] bus_addr;
    logic [7:0] bus_data_in, bus_data_out;
    logic req_valid, spi_active, par_active, host_busy;
    logic req_ready = 1'b0;
    logic rsp_valid = 1'b0;
    logic [7:0] rsp_data = 8'h00;
    hspp_pkg::hspp_req_s req;
    int failures = 0;
    int n_compared = 0;
    logic stall = 1'b0;
    logic jitter = 1'b0;
    logic [7:0] mem [logic [15:0]];
    logic [7:0] mdl [logic [15:0]];
    hspp_pkg::hspp_req_s exp_wr [$];
    logic [7:0] rd_q [$];
    logic [7:0] tx [8];
    logic [7:0] rx [8];
    logic [7:0] mode_m = 8'h00;
    logic [15:0] off = 16'h0000;
    logic [15:0] base;
    int n;

    // 250 MHz core clock
    always #2 ref_clk = ~ref_clk;

    hspp_top hspp_top_i (.ref_clk(ref_clk), .rst(rst), .host_if_select(host_if_select), .sclk(sclk),
        .scs_n(scs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
        .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .spi_active(spi_active), .par_active(par_active),
        .host_busy(host_busy));
    hspp_host_model hspp_host_model_i (.ref_clk(ref_clk), .sclk(sclk), .scs_n(scs_n), .mosi(mosi), .miso(miso),
        .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr),
        .bus_data_in(bus_data_in), .bus_data_out(bus_data_out));

    // compare tasks, one per kind of result
    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp1(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic cmp_req(input hspp_pkg::hspp_req_s e, input hspp_pkg::hspp_req_s g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH write request expected %h seen %h", e, g);
        end
    endtask

    // output enables checked once a select or read strobe has stood low for eight cycles
    int cs_lo = 0;
    int rd_lo = 0;
    always @(negedge ref_clk) begin
        cs_lo = scs_n ? 0 : cs_lo + 1;
        rd_lo = (bus_cs_n || bus_rd_n) ? 0 : rd_lo + 1;
        if (cs_lo == 8) cmp1("miso_oe", host_if_select == 4'h0, miso_oe);
        if (rd_lo == 8) cmp1("bus_data_oe", host_if_select[3:1] == 3'h2, bus_data_oe);
    end

    // memory sink: takes requests, checks writes against the model
    always @(posedge ref_clk) begin
        if (!rst && req_valid === 1'b1 && req_ready) begin
            if (req.we === 1'b1) begin
                cmp_req(exp_wr.size() != 0 ? exp_wr.pop_front() : '0, req);
                mem[req.addr] = req.data;
            end else begin
                rd_q.push_back(mem.exists(req.addr) ? mem[req.addr] : 8'h00);
            end
        end
    end
    // sink handshake and read answers
    always @(negedge ref_clk) begin
        req_ready <= !stall && (!jitter || ($urandom % 4 != 0));
        if (rd_q.size() != 0) begin
            rsp_valid <= 1'b1;
            rsp_data <= rd_q.pop_front();
        end else begin
            rsp_valid <= 1'b0;
            rsp_data <= ~rsp_data;
        end
    end

    // bus write with model update
    task automatic par_w(input logic [1:0] loc, input logic [7:0] v);
        case (loc)
            2'h0: mode_m = v;
            2'h1: off[15:8] = v;
            2'h2: off[7:0] = v;
            default: begin
                exp_wr.push_back({1'b1, off, v});
                mdl[off] = v;
                off++;
            end
        endcase
        hspp_host_model_i.par_write(loc, v);
    endtask
    // bus read compared with the model
    task automatic par_r(input logic [1:0] loc);
        logic [7:0] e;
        logic [7:0] g;
        e = loc == 2'h0 ? mode_m : loc == 2'h1 ? off[15:8] : loc == 2'h2 ? off[7:0] : mdl.exists(off) ? mdl[off] : 8'h00;
        hspp_host_model_i.par_read(loc, g);
        cmp8("parallel read", e, g);
        if (loc == 2'h3) begin
            off++;
        end
    endtask
    // serial frame with model update and read checks
    task automatic spi_xfer(input logic cpol, input logic [7:0] cmd, input logic [15:0] a, input int cnt);
        tx[0] = cmd;
        tx[1] = a[15:8];
        tx[2] = a[7:0];
        for (int k = 0; k < cnt; k++) begin
            tx[3+k] = 8'($urandom);
            if (cmd == `HSPP_CMD_WR) begin
                exp_wr.push_back({1'b1, a + 16'(k), tx[3+k]});
                mdl[a + 16'(k)] = tx[3+k];
            end
        end
        hspp_host_model_i.spi_frame(cpol, tx, cnt + 3, rx);
        for (int k = 0; k < cnt; k++) begin
            if (cmd == `HSPP_CMD_RD) begin
                cmp8("serial read", mdl.exists(a + 16'(k)) ? mdl[a + 16'(k)] : 8'h00, rx[3+k]);
            end
        end
    endtask
    // wait for every expected write to leave the buffer
    task automatic drain();
        for (int t = 0; t < 400 && exp_wr.size() != 0; t++) begin
            @(negedge ref_clk);
        end
        cmp8("pending writes", 8'h00, 8'(exp_wr.size()));
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        $display("watchdog expired");
        close_out();
    end
    // main sequence
    initial begin
        void'($urandom(32'h7019));
        host_if_select = 4'h5;
        repeat (4) @(posedge ref_clk);
        cmp1("miso_oe in reset", 1'b0, miso_oe);
        cmp1("bus_data_oe in reset", 1'b0, bus_data_oe);
        cmp1("req_valid in reset", 1'b0, req_valid);
        @(negedge ref_clk);
        rst <= 1'b0;
        jitter = 1'b1;
        repeat (8) @(negedge ref_clk);
        cmp1("par_active", 1'b1, par_active);
        cmp1("spi_active", 1'b0, spi_active);
        for (int l = 0; l < 3; l++) par_r(2'(l));
        par_w(2'h0, 8'($urandom));
        par_w(2'h1, 8'h12);
        par_w(2'h2, 8'hFE);
        for (int l = 0; l < 4; l++) par_w(2'h3, 8'($urandom));
        for (int l = 0; l < 3; l++) par_r(2'(l));
        par_w(2'h1, 8'h12);
        par_w(2'h2, 8'hFE);
        for (int l = 0; l < 4; l++) par_r(2'h3);
        par_r(2'h2);
        drain();
        $display("test parallel registers done");
        host_if_select = 4'h4;
        stall = 1'b1;
        repeat (8) @(negedge ref_clk);
        cmp1("par_active", 1'b1, par_active);
        par_w(2'h1, 8'h40);
        par_w(2'h2, 8'h00);
        for (int l = 0; l < `HSPP_FIFO_DEPTH; l++) par_w(2'h3, 8'($urandom));
        repeat (8) @(negedge ref_clk);
        cmp1("host_busy full", 1'b1, host_busy);
        stall = 1'b0;
        drain();
        repeat (4) @(negedge ref_clk);
        cmp1("host_busy empty", 1'b0, host_busy);
        $display("test buffer fill done");
        jitter = 1'b0;
        host_if_select = 4'h0;
        repeat (8) @(negedge ref_clk);
        cmp1("spi_active", 1'b1, spi_active);
        cmp1("par_active", 1'b0, par_active);
        for (int m = 0; m < 2; m++) begin
            base = 16'($urandom);
            n = 1 + $urandom % 4;
            spi_xfer(1'(m), `HSPP_CMD_WR, base, n);
            spi_xfer(1'(m), `HSPP_CMD_RD, base, n);
            spi_xfer(1'(m), 8'hA5, base, 2);
            spi_xfer(1'(m), `HSPP_CMD_RD, 16'h12FE, 5);
            drain();
        end
        $display("test serial frames done");
        close_out();
    end
endmodule // hspp_top_tb
